// ---- timer_cc_pkg.sv ----
/*
  Shared constants of the timer capture and compare unit: register word
  offsets, control and status bit positions and reset values.
  Assumes an APB slave with an 8-bit byte address and byte-wide registers
  sitting in the low bits of each aligned 32-bit word.
*/
package timer_cc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int         ADDR_WIDTH      = 8;
  localparam logic [7:0] CAP_HIGH_ADDR   = 8'h00;
  localparam logic [7:0] CAP_LOW_ADDR    = 8'h04;
  localparam logic [7:0] CMP_HIGH_ADDR   = 8'h10;
  localparam logic [7:0] CMP_LOW_ADDR    = 8'h14;
  localparam logic [7:0] CHANNEL_STRIDE  = 8'h08;
  localparam logic [7:0] CTRL_ONE_ADDR   = 8'h20;
  localparam logic [7:0] CTRL_TWO_ADDR   = 8'h24;
  localparam logic [7:0] STATUS_ADDR     = 8'h28;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h2c;
  localparam logic [7:0] COUNT_LOW_ADDR  = 8'h30;

  // ---------------------------------------------------------------
  // Control one: edges, levels and interrupt enables
  // ---------------------------------------------------------------
  localparam int EDGE_LSB       = 0;
  localparam int LEVEL_LSB      = 2;
  localparam int CMP_IRQ_EN_BIT = 6;
  localparam int CAP_IRQ_EN_BIT = 7;

  // ---------------------------------------------------------------
  // Control two: output enables, clock select and modes
  // ---------------------------------------------------------------
  localparam int OUT_EN_LSB     = 0;
  localparam int CLK_SEL_LSB    = 2;
  localparam int ONE_PULSE_BIT  = 4;
  localparam int PWM_BIT        = 5;
  localparam int EXT_EDGE_BIT   = 6;

  // ---------------------------------------------------------------
  // Status layout
  // ---------------------------------------------------------------
  localparam int CAP_FLAG_LSB   = 0;
  localparam int CMP_FLAG_LSB   = 2;

  // ---------------------------------------------------------------
  // Clock select codes and divider masks
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_DIV2     = 2'h0;
  localparam logic [1:0] CLK_DIV4     = 2'h1;
  localparam logic [1:0] CLK_DIV8     = 2'h2;
  localparam logic [1:0] CLK_EXTERNAL = 2'h3;
  localparam logic [2:0] MASK_DIV2    = 3'h1;
  localparam logic [2:0] MASK_DIV4    = 3'h3;
  localparam logic [2:0] MASK_DIV8    = 3'h7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNTER_RESET = 16'hfffc;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;

endpackage

// ---- pin_sync.sv ----
/*
  Three-stage synchroniser with edge detection for one pin.
  Assumes the pin is asynchronous to pclk; an edge is reported once the
  second and third stages agree on a level different from the last one.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic       level;
    logic       primed;
    logic [1:0] fill;
  } sync_type;

  sync_type s_q;
  sync_type s_d;
  logic     agree;

  // The first stage feeds only the second stage.
  assign agree = (s_q.s2 == s_q.s3);
  assign rise  = agree & s_q.primed & s_q.s3 & ~s_q.level;
  assign fall  = agree & s_q.primed & ~s_q.s3 & s_q.level;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (!(&s_q.fill)) begin
      s_d.fill = s_q.fill + 2'h1;
    end
    // The stages hold reset zeros, not pin samples, until they have
    // filled. Only then is the first agreed level taken, silently, so
    // a pin that idles high does not fake an edge after reset.
    if (agree && (&s_q.fill)) begin
      s_d.level  = s_q.s3;
      s_d.primed = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

// ---- timer_capture_compare_unit.sv ----
/*
  Capture and compare unit of a 16-bit timer with its free-running
  counter, tick divider and byte-wide registers on an APB slave.
  Assumes pins arrive asynchronously and the CPU interrupt mask is a
  level from logic on pclk.
*/
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
//
// Overview of operation
// - Each capture channel latches the 16-bit counter on its active pin edge.
// - Capture value registers are read-only; writes leave them unchanged.
// - Each channel's edge select bit picks the active capture polarity.
// - A capture sets the channel flag and holds the sampled counter value.
// - Capture requests interrupt when enabled and mask clear, else pending.
// - One capture interrupt enable covers both capture channels.
// - Capture flag clears after status read then capture low byte access.
// - Reading capture high byte blocks captures and flag until low read.
// - Each new capture overwrites the previous value.
// - In one-pulse or PWM mode only capture channel 2 captures.
// - Capture pins always feed capture logic, even when driven as outputs.
// - Both compare values match against the counter every timer cycle.
// - Compare values are read/write, hardware never alters them, reset 8000h.
// - A match sets compare flag and drives level when output enabled.
// - Compare pin latches stay low during reset.
// - Compare match requests interrupt when enabled and mask clear.
// - Compare flag clears after status read then compare low access.
// - Writing compare high byte inhibits compare until low byte write.
// - Suggested order high, status, low; low write re-enables and clears.
// - Without output enable the pin ignores level; interrupts still work.
// - Flag and pin update while counter equals the compare value.
// - The free-running counter resets to FFFCh.
// - Clock select gives CPU clock over 2, 4, 8 or external pin.
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_unit
  import timer_cc_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Timer pins
  input  wire logic [CHANNELS-1:0]   capture_pin,
  input  wire logic                  ext_clock_pin,
  output logic      [CHANNELS-1:0]   compare_pin_out,
  output logic      [CHANNELS-1:0]   compare_pin_oe,
  // CPU interrupt
  input  wire logic                  global_irq_mask,
  output logic                       timer_irq_req
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (CHANNELS != 2) begin : g_bad_channels
    $error("timer unit: register map serves exactly two channels");
  end

  typedef struct packed {
    logic [2:0]                 presc;
    logic [15:0]                counter;
    logic [CHANNELS-1:0][15:0]  cap_val;
    logic [CHANNELS-1:0]        cap_flag;
    logic [CHANNELS-1:0]        cap_arm;
    logic [CHANNELS-1:0]        cap_block;
    logic [CHANNELS-1:0][15:0]  cmp_val;
    logic [CHANNELS-1:0]        cmp_flag;
    logic [CHANNELS-1:0]        cmp_arm;
    logic [CHANNELS-1:0]        cmp_inhibit;
    logic [CHANNELS-1:0]        cmp_pin;
    logic [7:0]                 ctrl_one;
    logic [7:0]                 ctrl_two;
    logic [7:0]                 rdata;
    logic                       pready;
    logic                       pslverr;
    logic                       irq;
  } state_type;

  localparam state_type STATE_RESET = '{
    presc:   3'h0,
    counter: COUNTER_RESET,
    cmp_val: {CHANNELS{COMPARE_RESET}},
    default: '0
  };

  state_type           s_q;
  state_type           s_d;
  logic [CHANNELS-1:0] cap_rise;
  logic [CHANNELS-1:0] cap_fall;
  logic [CHANNELS-1:0] cap_event;
  logic [CHANNELS-1:0] cap_high_rd;
  logic [CHANNELS-1:0] cap_low_acc;
  logic [CHANNELS-1:0] cmp_match;
  logic [CHANNELS-1:0] cmp_high_wr;
  logic [CHANNELS-1:0] cmp_low_wr;
  logic [CHANNELS-1:0] cmp_low_acc;
  logic                ext_rise;
  logic                ext_fall;
  logic                setup;
  logic                done;
  logic                status_rd;
  logic                tick;
  logic [2:0]          div_mask;
  logic [1:0]          clk_sel;
  logic                narrow_mode;

  assign setup       = psel & ~penable;
  assign done        = psel & penable & s_q.pready;
  assign status_rd   = done & ~pwrite & (paddr == STATUS_ADDR);
  assign clk_sel     = s_q.ctrl_two[CLK_SEL_LSB +: 2];
  assign narrow_mode = s_q.ctrl_two[ONE_PULSE_BIT] | s_q.ctrl_two[PWM_BIT];

  // ---------------------------------------------------------------
  // Timer tick
  // ---------------------------------------------------------------
  pin_sync u_ext_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  always_comb begin
    unique case (clk_sel)
      CLK_DIV2: div_mask = MASK_DIV2;
      CLK_DIV4: div_mask = MASK_DIV4;
      default:  div_mask = MASK_DIV8;
    endcase
  end

  assign tick = (clk_sel == CLK_EXTERNAL) ?
                (s_q.ctrl_two[EXT_EDGE_BIT] ? ext_rise : ext_fall) :
                ((s_q.presc & div_mask) == div_mask);

  // ---------------------------------------------------------------
  // Per-channel decode and events
  // ---------------------------------------------------------------
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    localparam logic [7:0] OFS = 8'(i * CHANNEL_STRIDE);

    // pin always feeds the capture path
    pin_sync u_cap_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (capture_pin[i]),
      .rise    (cap_rise[i]),
      .fall    (cap_fall[i])
    );

    // channel one idles in pulse modes
    assign cap_event[i] = ((i != 0) | ~narrow_mode) &
                          (s_q.ctrl_one[EDGE_LSB + i] ? cap_rise[i]
                                                      : cap_fall[i]);
    assign cap_high_rd[i] = done & ~pwrite &
                            (paddr == CAP_HIGH_ADDR + OFS);
    assign cap_low_acc[i] = done & (paddr == CAP_LOW_ADDR + OFS);

    assign cmp_match[i] = (s_q.counter == s_q.cmp_val[i]) &
                          ~s_q.cmp_inhibit[i];
    assign cmp_high_wr[i] = done & pwrite &
                            (paddr == CMP_HIGH_ADDR + OFS);
    assign cmp_low_acc[i] = done & (paddr == CMP_LOW_ADDR + OFS);
    assign cmp_low_wr[i]  = cmp_low_acc[i] & pwrite;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.presc = s_q.presc + 3'h1;

    if (tick) begin
      s_d.counter = s_q.counter + 16'h0001;
    end

    for (int i = 0; i < CHANNELS; i++) begin
      // second step clears an armed flag
      // Only a read of the low byte lifts the high-byte block.
      if (cap_low_acc[i]) begin
        s_d.cap_block[i] = s_q.cap_block[i] & pwrite;
        if (s_q.cap_arm[i]) begin
          s_d.cap_flag[i] = 1'b0;
          s_d.cap_arm[i]  = 1'b0;
        end
      end
      // high byte read freezes the channel
      if (cap_high_rd[i]) begin
        s_d.cap_block[i] = 1'b1;
      end
      // Arm only on the flag value that the status read returned, so a
      // flag that rose after the data was fetched is never cleared unseen.
      if (status_rd && s_q.rdata[CAP_FLAG_LSB + i]) begin
        s_d.cap_arm[i] = 1'b1;
      end
      // flag set wins over a clear
      if (cap_event[i] && !s_q.cap_block[i]) begin
        s_d.cap_val[i]  = s_q.counter;
        s_d.cap_flag[i] = 1'b1;
        s_d.cap_arm[i]  = 1'b0;
      end

      if (cmp_high_wr[i]) begin
        s_d.cmp_val[i][15:8]  = pwdata[7:0];
        s_d.cmp_inhibit[i]    = 1'b1;
      end
      if (cmp_low_wr[i]) begin
        s_d.cmp_val[i][7:0]   = pwdata[7:0];
        s_d.cmp_inhibit[i]    = 1'b0;
      end
      if (cmp_low_acc[i] && s_q.cmp_arm[i]) begin
        s_d.cmp_flag[i] = 1'b0;
        s_d.cmp_arm[i]  = 1'b0;
      end
      if (status_rd && s_q.rdata[CMP_FLAG_LSB + i]) begin
        s_d.cmp_arm[i] = 1'b1;
      end
      // flag and pin follow while equal
      // match sets flag and drives level
      if (cmp_match[i]) begin
        s_d.cmp_flag[i] = 1'b1;
        s_d.cmp_arm[i]  = 1'b0;
        if (s_q.ctrl_two[OUT_EN_LSB + i]) begin
          s_d.cmp_pin[i] = s_q.ctrl_one[LEVEL_LSB + i];
        end
      end
    end

    if (done && pwrite && paddr == CTRL_ONE_ADDR) begin
      s_d.ctrl_one = pwdata[7:0];
    end
    if (done && pwrite && paddr == CTRL_TWO_ADDR) begin
      s_d.ctrl_two = pwdata[7:0];
    end

    // Read data is fetched in the setup cycle so every output comes
    // from a flop; pready then rises for a zero-wait access phase.
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    s_d.rdata   = 8'h00;
    if (setup) begin
      unique case (paddr)
        CAP_HIGH_ADDR:                  s_d.rdata = s_q.cap_val[0][15:8];
        CAP_LOW_ADDR:                   s_d.rdata = s_q.cap_val[0][7:0];
        CAP_HIGH_ADDR + CHANNEL_STRIDE: s_d.rdata = s_q.cap_val[1][15:8];
        CAP_LOW_ADDR + CHANNEL_STRIDE:  s_d.rdata = s_q.cap_val[1][7:0];
        CMP_HIGH_ADDR:                  s_d.rdata = s_q.cmp_val[0][15:8];
        CMP_LOW_ADDR:                   s_d.rdata = s_q.cmp_val[0][7:0];
        CMP_HIGH_ADDR + CHANNEL_STRIDE: s_d.rdata = s_q.cmp_val[1][15:8];
        CMP_LOW_ADDR + CHANNEL_STRIDE:  s_d.rdata = s_q.cmp_val[1][7:0];
        CTRL_ONE_ADDR:                  s_d.rdata = s_q.ctrl_one;
        CTRL_TWO_ADDR:                  s_d.rdata = s_q.ctrl_two;
        STATUS_ADDR: begin
          s_d.rdata[CAP_FLAG_LSB +: 2] = s_q.cap_flag;
          s_d.rdata[CMP_FLAG_LSB +: 2] = s_q.cmp_flag;
        end
        COUNT_HIGH_ADDR:                s_d.rdata = s_q.counter[15:8];
        COUNT_LOW_ADDR:                 s_d.rdata = s_q.counter[7:0];
        default:                        s_d.pslverr = 1'b1;
      endcase
    end

    // pending flags wait for enable and mask
    s_d.irq = ~global_irq_mask &
              ((s_q.ctrl_one[CAP_IRQ_EN_BIT] & (|s_q.cap_flag)) |
               (s_q.ctrl_one[CMP_IRQ_EN_BIT] & (|s_q.cmp_flag)));
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // compare latches reset low
  // counter restarts at its reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata          = {24'h000000, s_q.rdata};
  assign pready          = s_q.pready;
  assign pslverr         = s_q.pslverr;
  assign compare_pin_out = s_q.cmp_pin;
  assign compare_pin_oe  = s_q.ctrl_two[OUT_EN_LSB +: CHANNELS];
  assign timer_irq_req   = s_q.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_latch:
    assert property (cap_event[1] && !s_q.cap_block[1] |=>
                     s_q.cap_val[1] == $past(s_q.counter) && s_q.cap_flag[1])
    else $error("capture did not latch the counter");

  a_capture_readonly:
    assert property (done && pwrite && !cap_event[0] |=>
                     $stable(s_q.cap_val[0]))
    else $error("capture value changed without an event");

  a_capture_blocked:
    assert property (s_q.cap_block[0] && !s_q.cap_flag[0] |=>
                     !s_q.cap_flag[0] && $stable(s_q.cap_val[0]))
    else $error("blocked capture channel updated");

  a_pulse_mode_cap:
    assert property (narrow_mode |-> !cap_event[0])
    else $error("channel one captured in a pulse mode");

  a_irq_masked:
    assert property (global_irq_mask |=> !timer_irq_req)
    else $error("interrupt raised while masked");

  a_irq_compare:
    assert property (cmp_match[0] && s_q.ctrl_one[CMP_IRQ_EN_BIT] &&
                     !global_irq_mask ##1 !global_irq_mask |=>
                     timer_irq_req)
    else $error("compare match raised no interrupt");

  a_compare_hold:
    assert property (!cmp_high_wr[0] && !cmp_low_wr[0] |=>
                     $stable(s_q.cmp_val[0]))
    else $error("compare value changed without a write");

  a_compare_pin:
    assert property (cmp_match[1] && s_q.ctrl_two[OUT_EN_LSB + 1] |=>
                     compare_pin_out[1] == $past(s_q.ctrl_one[LEVEL_LSB + 1]))
    else $error("compare pin did not take the level");

  a_pin_no_enable:
    assert property (!s_q.ctrl_two[OUT_EN_LSB] |=>
                     $stable(compare_pin_out[0]))
    else $error("disabled compare pin changed");

  a_inhibit_match:
    assert property (cmp_high_wr[0] |=> !cmp_match[0] throughout
                     (!cmp_low_wr[0])[*2])
    else $error("compare matched while inhibited");

  a_flag_clear:
    assert property ($fell(s_q.cmp_flag[0]) |->
                     $past(s_q.cmp_arm[0]) && $past(cmp_low_acc[0]))
    else $error("compare flag cleared without the two steps");

  a_cap_flag_clear:
    assert property ($fell(s_q.cap_flag[1]) |->
                     $past(s_q.cap_arm[1]) && $past(cap_low_acc[1]))
    else $error("capture flag cleared without the two steps");

endmodule

`default_nettype wire

// ---- timer_pin_partner.sv ----
/*
  Pin-side partner of the timer unit: capture sources, an external
  clock source and a pull-down load on each compare pin.
  Assumes the bench calls its tasks and that pclk runs throughout.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_pin_partner (
  // Clock
  input  wire logic       pclk,
  // Pins driven into the unit
  output logic      [1:0] capture_pin,
  output logic            ext_clock_pin,
  // Compare pins as the board sees them
  input  wire logic [1:0] compare_pin_out,
  input  wire logic [1:0] compare_pin_oe,
  output logic      [1:0] compare_pin_level
);
  // ---------------------------------------------------------------
  // Pin behaviour
  // ---------------------------------------------------------------
  initial begin
    capture_pin   = 2'h0;
    ext_clock_pin = 1'b0;
  end

  // A released compare pin falls to its pull-down, never the last level.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      compare_pin_level[i] = compare_pin_oe[i] ? compare_pin_out[i] : 1'b0;
    end
  end

  // Holding long enough lets the capture, its flag and the request land.
  task automatic set_capture(input int ch, input logic level);
    @(posedge pclk);
    capture_pin[ch] <= level;
    repeat (8) @(posedge pclk);
  endtask

  // One falling edge per tick, far slower than a quarter of pclk.
  task automatic ext_ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clock_pin <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule

`default_nettype wire

// ---- timer_capture_compare_unit_bench.sv ----
/*
  Self-checking bench of the timer capture and compare unit.
  Assumes the pin partner model and an APB master built from tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_unit_bench
  import timer_cc_pkg::*;
;
  localparam logic [7:0] CAP2_HIGH = CAP_HIGH_ADDR + CHANNEL_STRIDE;
  localparam logic [7:0] CAP2_LOW  = CAP_LOW_ADDR + CHANNEL_STRIDE;
  localparam logic [7:0] CMP2_HIGH = CMP_HIGH_ADDR + CHANNEL_STRIDE;
  localparam logic [7:0] CMP2_LOW  = CMP_LOW_ADDR + CHANNEL_STRIDE;

  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  capture_pin;
  logic        ext_clock_pin;
  logic [1:0]  compare_pin_out;
  logic [1:0]  compare_pin_oe;
  logic [1:0]  compare_pin_level;
  logic        global_irq_mask;
  logic        timer_irq_req;
  logic [7:0]  rdata;
  logic        rerr;
  logic [15:0] cnt;
  logic [15:0] cmp;
  int          failures;
  int          checked;

  timer_capture_compare_unit dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .ext_clock_pin(ext_clock_pin), .compare_pin_out(compare_pin_out),
    .compare_pin_oe(compare_pin_oe), .global_irq_mask(global_irq_mask),
    .timer_irq_req(timer_irq_req)
  );

  timer_pin_partner pins (
    .pclk(pclk), .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
    .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
    .compare_pin_level(compare_pin_level)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask

  // The request stands until the edge that samples pready high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
    rdata   = prdata[7:0];
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk_byte(rdata, exp);
  endtask

  // Status, then high, then low: the low read also clears the flag.
  task automatic cap_read(input logic [7:0] hi, input logic [7:0] lo,
                          input logic [7:0] stat, input logic [15:0] exp);
    rd_chk(STATUS_ADDR, stat);
    rd_chk(hi, exp[15:8]);
    rd_chk(lo, exp[7:0]);
    rd_chk(STATUS_ADDR, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn         = 1'b0;
    paddr           = 8'h00;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    pwdata          = 32'h0;
    global_irq_mask = 1'b1;
    failures        = 0;
    checked         = 0;
    repeat (10) @(posedge pclk);
    chk_byte({6'h0, compare_pin_out}, 8'h00);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(CMP_HIGH_ADDR, 8'h80);
    rd_chk(CMP_LOW_ADDR, 8'h00);
    rd_chk(CMP2_HIGH, 8'h80);
    rd_chk(CMP2_LOW, 8'h00);
    rd(8'h3c);
    chk_bit(rerr, 1'b1);
    // The idle external clock freezes the counter, so values are exact.
    wr(CTRL_TWO_ADDR, 8'h0d);
    rd(COUNT_HIGH_ADDR);
    cnt[15:8] = rdata;
    rd(COUNT_LOW_ADDR);
    cnt[7:0] = rdata;
    wr(CTRL_ONE_ADDR, 8'h85);
    pins.set_capture(0, 1'b1);
    chk_bit(timer_irq_req, 1'b0);
    global_irq_mask <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(timer_irq_req, 1'b1);
    wr(CAP_HIGH_ADDR, 8'h55);
    cap_read(CAP_HIGH_ADDR, CAP_LOW_ADDR, 8'h01, cnt);
    chk_bit(timer_irq_req, 1'b0);
    pins.set_capture(0, 1'b0);
    rd_chk(STATUS_ADDR, 8'h00);
    pins.ext_ticks(3);
    cnt = cnt + 16'h0003;
    pins.set_capture(1, 1'b1);
    pins.set_capture(1, 1'b0);
    chk_bit(timer_irq_req, 1'b1);
    cap_read(CAP2_HIGH, CAP2_LOW, 8'h02, cnt);
    rd(CAP_HIGH_ADDR);
    pins.set_capture(0, 1'b1);
    rd_chk(STATUS_ADDR, 8'h00);
    rd_chk(CAP_LOW_ADDR, 8'(cnt - 16'h0003));
    pins.set_capture(0, 1'b0);
    pins.set_capture(0, 1'b1);
    cap_read(CAP_HIGH_ADDR, CAP_LOW_ADDR, 8'h01, cnt);
    wr(CTRL_TWO_ADDR, 8'h1d);
    pins.set_capture(0, 1'b0);
    pins.set_capture(0, 1'b1);
    pins.set_capture(1, 1'b1);
    pins.set_capture(1, 1'b0);
    cap_read(CAP2_HIGH, CAP2_LOW, 8'h02, cnt);
    wr(CTRL_TWO_ADDR, 8'h0d);
    cmp = cnt + 16'h0002;
    wr(CMP_HIGH_ADDR, cmp[15:8]);
    wr(CMP_LOW_ADDR, cmp[7:0]);
    pins.ext_ticks(1);
    rd_chk(STATUS_ADDR, 8'h00);
    wr(CMP_HIGH_ADDR, cmp[15:8]);
    pins.ext_ticks(1);
    rd_chk(STATUS_ADDR, 8'h00);
    chk_bit(compare_pin_out[0], 1'b0);
    wr(CMP_LOW_ADDR, cmp[7:0]);
    rd_chk(STATUS_ADDR, 8'h04);
    chk_byte({4'h0, compare_pin_oe, compare_pin_level}, 8'h05);
    chk_bit(timer_irq_req, 1'b0);
    wr(CTRL_ONE_ADDR, 8'hcd);
    repeat (2) @(posedge pclk);
    chk_bit(timer_irq_req, 1'b1);
    wr(CMP2_HIGH, cmp[15:8]);
    wr(CMP2_LOW, cmp[7:0]);
    repeat (2) @(posedge pclk);
    chk_byte({4'h0, compare_pin_oe, compare_pin_out}, 8'h05);
    pins.ext_ticks(1);
    rd_chk(STATUS_ADDR, 8'h0c);
    rd_chk(CMP_LOW_ADDR, cmp[7:0]);
    rd_chk(STATUS_ADDR, 8'h08);
    rd_chk(CMP_HIGH_ADDR, cmp[15:8]);
    give_verdict();
  end
endmodule

`default_nettype wire
